// [hw/hbq_pkg.sv]
// package of constants and types for the heartbeat hold-off qualifier
package hbq_pkg;
  // ------------------------------------------------------------
  // register map (word addresses; printed index used as is)
  // ------------------------------------------------------------
  localparam logic [7:0] HBQ_IDX_TIMING = 8'h1E; // timing config index
  localparam logic [7:0] HBQ_IDX_CTRL = 8'h1F; // control index
  localparam logic [7:0] HBQ_IDX_STATUS = 8'h20; // status index
  localparam logic [7:0] HBQ_IDX_MASK = 8'h21; // mask index
  localparam logic [7:0] HBQ_IDX_INTERVAL = 8'h22; // beat interval index
  localparam logic [7:0] HBQ_IDX_AVERAGE = 8'h23; // running average index
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int HBQ_STATIC_HOLDOFF_TICKS_LSB = 16; // static hold-off field low bit
  localparam int HBQ_INTERVAL_AVERAGE_WEIGHT_LSB = 12; // average weight field low bit
  localparam int HBQ_DYNAMIC_HOLDOFF_SCALE_LSB = 8; // dynamic scale field low bit
  localparam logic [5:0] HBQ_STATIC_HOLDOFF_TICKS_RST = 6'h20; // 32 ticks
  localparam logic [1:0] HBQ_INTERVAL_AVERAGE_WEIGHT_RST = 2'h2; // weight 8
  localparam logic [2:0] HBQ_DYNAMIC_HOLDOFF_SCALE_RST = 3'h4; // 4/8
  localparam logic [23:0] HBQ_TIMING_MASK = 24'h3F3700; // writable bits
  localparam int HBQ_IVL_W = 14; // interval width in ticks
  localparam int HBQ_ST_BEAT = 0; // status bit: beat accepted
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int HBQ_CLK_HZ = 10_000_000; // master clock rate
  localparam int HBQ_TICK_US = 8000; // detector tick, about 8 ms
  localparam int HBQ_TICK_CYC = HBQ_TICK_US * (HBQ_CLK_HZ / 1_000_000); // cycles per tick
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [5:0] static_holdoff_ticks; // static hold-off ticks
    logic [1:0] interval_average_weight; // averaging weight code
    logic [2:0] dynamic_holdoff_scale; // dynamic scale code
  } hbq_timing_s;
  typedef enum logic [1:0] {
    HBQ_IDLE = 2'b00, // waiting for detection enable
    HBQ_HOLD = 2'b01, // hold-off interval running
    HBQ_ARMED = 2'b11 // candidates accepted
  } hbq_state_e;
endpackage

// [hw/hbq_tick_div.sv]
// divider making the detector tick enable
`timescale 1ns/1ps
module hbq_tick_div #(
  parameter int TICK_CYC = hbq_pkg::HBQ_TICK_CYC
) (
  input wire logic clk_i, // master clock
  input wire logic nrst_i, // async reset, active low
  input wire logic run_i, // count while high
  output logic tick_o // one-cycle tick pulse
);
  import hbq_pkg::*;
  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  logic [19:0] cnt_r; // cycles within tick
  localparam logic [19:0] LAST = 20'(TICK_CYC - 1); // last count
  // count and pulse at the wrap
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= 20'h00000;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_r <= 20'h00000;
      tick_o <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r <= 20'h00000;
      tick_o <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 20'h00001;
      tick_o <= 1'b0;
    end
  end
endmodule // hbq_tick_div

// [hw/hbq_top.sv]
// heartbeat hold-off qualifier with Avalon-MM register slave
// Contract
// - six-bit static hold-off, reset 32
// - static time equals setting times tick
// - hold-off is max of static, dynamic
// - two-bit weight: 2, 4, 8; reset 8
// - smaller weight tracks newest interval closer
// - dynamic equals average times scale over eight
// - scale zero means static hold-off only
// - runs only when enabled and channel enabled
// - accepted beat updates interval, sets flag
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
module hbq_top #(
  parameter int TICK_CYC = hbq_pkg::HBQ_TICK_CYC // cycles per detector tick
) (
  input wire logic clk_i, // 10 MHz master clock
  input wire logic nrst_i, // async reset, active low
  input wire logic [7:0] avs_address_i, // word address
  input wire logic avs_read_i, // read strobe
  input wire logic avs_write_i, // write strobe
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte enables
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  input wire logic channel_enable_i, // measurement channel enabled
  input wire logic r_event_i, // candidate R event pulse
  output logic beat_accept_o, // accepted beat pulse
  output logic irq_o // level interrupt
);
  import hbq_pkg::*;
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  hbq_timing_s cfg_r; // timing fields
  logic beat_detect_enable_r; // detection enable
  logic [0:0] status_r; // sticky status
  logic [0:0] mask_r; // interrupt mask
  logic [HBQ_IVL_W-1:0] beat_interval_value_r; // last accepted interval
  logic [HBQ_IVL_W+3:0] avg_r; // running average, 4 fraction bits
  logic [HBQ_IVL_W-1:0] elapsed_r; // ticks since last beat
  logic [HBQ_IVL_W-1:0] holdoff_r; // effective hold-off ticks
  hbq_state_e state_r; // qualifier state
  logic ack_r; // access answered
  logic tick; // detector tick enable
  logic run; // detection running
  logic wr_hit; // write taken this cycle
  logic accept; // candidate accepted
  logic [31:0] wmask; // byte lanes as bit mask

  // byte enables to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // index match for the current access
  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == idx);
  endfunction

  assign run = beat_detect_enable_r & channel_enable_i;
  assign wmask = lane_mask(avs_byteenable_i);
  assign wr_hit = avs_write_i & ack_r;

  // ------------------------------------------------------------
  // tick divider
  // ------------------------------------------------------------
  hbq_tick_div #(
    .TICK_CYC(TICK_CYC)
  ) u_div (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .run_i(run),
    .tick_o(tick)
  );

  // ------------------------------------------------------------
  // bus handshake: one wait cycle, answer on the second
  // ------------------------------------------------------------
  // waitrequest low one cycle after a request appears; kept as a flop of its own
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_r <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack_r);
    end
  end

  // read data mux, registered when the access starts
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i & ~ack_r) begin
      if (hit(avs_address_i, HBQ_IDX_TIMING)) begin
        avs_readdata_o <= {10'h000, cfg_r.static_holdoff_ticks, 2'h0, cfg_r.interval_average_weight, 1'b0, cfg_r.dynamic_holdoff_scale, 8'h00};
      end else if (hit(avs_address_i, HBQ_IDX_CTRL)) begin
        avs_readdata_o <= {31'h00000000, beat_detect_enable_r};
      end else if (hit(avs_address_i, HBQ_IDX_STATUS)) begin
        avs_readdata_o <= {31'h00000000, status_r};
      end else if (hit(avs_address_i, HBQ_IDX_MASK)) begin
        avs_readdata_o <= {31'h00000000, mask_r};
      end else if (hit(avs_address_i, HBQ_IDX_INTERVAL)) begin
        // left justified in 24 bits
        avs_readdata_o <= {8'h00, beat_interval_value_r, 10'h000};
      end else if (hit(avs_address_i, HBQ_IDX_AVERAGE)) begin
        avs_readdata_o <= {18'h00000, avg_r[HBQ_IVL_W+3:4]};
      end else begin
        // unmapped reads return zero
        avs_readdata_o <= 32'h00000000;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration writes
  // ------------------------------------------------------------
  // timing register with its reset values
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_r.static_holdoff_ticks <= HBQ_STATIC_HOLDOFF_TICKS_RST;
      cfg_r.interval_average_weight <= HBQ_INTERVAL_AVERAGE_WEIGHT_RST;
      cfg_r.dynamic_holdoff_scale <= HBQ_DYNAMIC_HOLDOFF_SCALE_RST;
    end else if (wr_hit && hit(avs_address_i, HBQ_IDX_TIMING)) begin
      if (avs_byteenable_i[2]) begin
        cfg_r.static_holdoff_ticks <= avs_writedata_i[HBQ_STATIC_HOLDOFF_TICKS_LSB +: 6];
      end
      if (avs_byteenable_i[1]) begin
        // code 11 is not defined; map it to the default weight
        cfg_r.interval_average_weight <= (avs_writedata_i[HBQ_INTERVAL_AVERAGE_WEIGHT_LSB +: 2] == 2'h3) ? HBQ_INTERVAL_AVERAGE_WEIGHT_RST :
                      avs_writedata_i[HBQ_INTERVAL_AVERAGE_WEIGHT_LSB +: 2];
        cfg_r.dynamic_holdoff_scale <= avs_writedata_i[HBQ_DYNAMIC_HOLDOFF_SCALE_LSB +: 3];
      end
    end
  end

  // control and mask registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      beat_detect_enable_r <= 1'b0;
      mask_r <= 1'b0;
    end else if (wr_hit && avs_byteenable_i[0]) begin
      if (hit(avs_address_i, HBQ_IDX_CTRL)) begin
        beat_detect_enable_r <= avs_writedata_i[0];
      end
      if (hit(avs_address_i, HBQ_IDX_MASK)) begin
        mask_r <= avs_writedata_i[0];
      end
    end
  end

  // ------------------------------------------------------------
  // hold-off computation
  // ------------------------------------------------------------
  // effective hold-off in ticks from static and dynamic parts
  always_ff @(posedge clk_i or negedge nrst_i) begin
    logic [HBQ_IVL_W+6:0] prod; // average times scale, 7 fraction bits
    logic [HBQ_IVL_W-1:0] dyn; // dynamic hold-off ticks
    logic [HBQ_IVL_W-1:0] stat; // static hold-off ticks
    if (!nrst_i) begin
      holdoff_r <= {8'h00, HBQ_STATIC_HOLDOFF_TICKS_RST};
    end else begin
      prod = 21'(avg_r) * 21'(cfg_r.dynamic_holdoff_scale);
      dyn = prod[HBQ_IVL_W+6:7]; // divide by eight and drop fraction
      stat = {8'h00, cfg_r.static_holdoff_ticks};
      if (cfg_r.dynamic_holdoff_scale == 3'h0) begin
        holdoff_r <= stat;
      end else begin
        holdoff_r <= (dyn > stat) ? dyn : stat;
      end
    end
  end

  // ------------------------------------------------------------
  // qualifier state machine
  // ------------------------------------------------------------
  // candidate accepted only when armed; early ones are dropped
  assign accept = run & r_event_i & (state_r == HBQ_ARMED);

  // state and elapsed tick counter
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= HBQ_IDLE;
      elapsed_r <= 14'h0000;
    end else if (!run) begin
      state_r <= HBQ_IDLE;
      elapsed_r <= 14'h0000;
    end else begin
      case (state_r)
        HBQ_IDLE: begin
          state_r <= HBQ_HOLD;
          elapsed_r <= 14'h0000;
        end
        HBQ_HOLD: begin
          if (tick) begin
            elapsed_r <= elapsed_r + 14'h0001; // rolls over at overflow
          end
          if (elapsed_r >= holdoff_r) begin
            state_r <= HBQ_ARMED;
          end
        end
        HBQ_ARMED: begin
          if (accept) begin
            state_r <= HBQ_HOLD;
            elapsed_r <= 14'h0000;
          end else if (tick) begin
            elapsed_r <= elapsed_r + 14'h0001;
          end
        end
        default: begin
          state_r <= HBQ_IDLE;
        end
      endcase
    end
  end

  // interval capture and running average
  always_ff @(posedge clk_i or negedge nrst_i) begin
    logic [HBQ_IVL_W+3:0] cur; // newest interval, 4 fraction bits
    if (!nrst_i) begin
      beat_interval_value_r <= 14'h0000;
      avg_r <= 18'h00000;
    end else if (accept) begin
      cur = {elapsed_r, 4'h0};
      beat_interval_value_r <= elapsed_r;
      // avg += (cur - avg) / weight; shift 1, 2 or 3
      if (cur >= avg_r) begin
        avg_r <= avg_r + ((cur - avg_r) >> (cfg_r.interval_average_weight + 2'h1));
      end else begin
        avg_r <= avg_r - ((avg_r - cur) >> (cfg_r.interval_average_weight + 2'h1));
      end
    end
  end

  // ------------------------------------------------------------
  // status, interrupt, beat pulse
  // ------------------------------------------------------------
  // sticky flag; a set wins over a write-one clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_r <= 1'b0;
      irq_o <= 1'b0;
      beat_accept_o <= 1'b0;
    end else begin
      if (accept) begin
        status_r[HBQ_ST_BEAT] <= 1'b1;
      end else if (wr_hit && hit(avs_address_i, HBQ_IDX_STATUS) &&
                   (avs_writedata_i[0] & wmask[0])) begin
        status_r[HBQ_ST_BEAT] <= 1'b0;
      end
      irq_o <= |((status_r | {accept}) & mask_r);
      beat_accept_o <= accept;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_static_holdoff_ticks_reset;
    @(posedge clk_i) $rose(nrst_i) |-> (cfg_r.static_holdoff_ticks == 6'h20 && cfg_r.interval_average_weight == 2'h2);
  endproperty
  a_static_holdoff_ticks_reset: assert property (p_static_holdoff_ticks_reset) else $error("timing reset wrong");

  property p_static_floor;
    @(posedge clk_i) disable iff (!nrst_i) accept |-> elapsed_r >= {8'h00, cfg_r.static_holdoff_ticks};
  endproperty
  a_static_floor: assert property (p_static_floor) else $error("beat before static hold-off");

  property p_max_rule;
    @(posedge clk_i) disable iff (!nrst_i)
      ##1 (holdoff_r >= {8'h00, $past(cfg_r.static_holdoff_ticks)});
  endproperty
  a_max_rule: assert property (p_max_rule) else $error("hold-off below static part");

  property p_weight_legal;
    @(posedge clk_i) disable iff (!nrst_i) cfg_r.interval_average_weight != 2'h3;
  endproperty
  a_weight_legal: assert property (p_weight_legal) else $error("illegal weight code");

  property p_avg_move;
    @(posedge clk_i) disable iff (!nrst_i)
      (accept && {elapsed_r, 4'h0} > avg_r + 18'h00010) |=> avg_r > $past(avg_r);
  endproperty
  a_avg_move: assert property (p_avg_move) else $error("average did not follow");

  property p_static_only;
    @(posedge clk_i) disable iff (!nrst_i)
      (cfg_r.dynamic_holdoff_scale == 3'h0) [*2] |-> holdoff_r == {8'h00, $past(cfg_r.static_holdoff_ticks)};
  endproperty
  a_static_only: assert property (p_static_only) else $error("dynamic used at scale zero");

  property p_disabled;
    @(posedge clk_i) disable iff (!nrst_i) !run |-> !accept ##1 state_r == HBQ_IDLE;
  endproperty
  a_disabled: assert property (p_disabled) else $error("active while disabled");

  property p_flag_set;
    @(posedge clk_i) disable iff (!nrst_i)
      accept |=> status_r[0] && beat_interval_value_r == $past(elapsed_r) && beat_accept_o;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("accepted beat not recorded");

  property p_early_ignored;
    @(posedge clk_i) disable iff (!nrst_i)
      (r_event_i && state_r == HBQ_HOLD) |=> $stable(beat_interval_value_r) && $stable(avg_r);
  endproperty
  a_early_ignored: assert property (p_early_ignored) else $error("early candidate taken");
endmodule // hbq_top

// [verification/hbq_tb.sv]
// self-checking testbench for the heartbeat hold-off qualifier
`timescale 1ns/1ps
module tb;
  import hbq_pkg::*;
  localparam int TC = 10; // cycles per detector tick in simulation
  logic clk_i, nrst_i, avs_read_i, avs_write_i, channel_enable_i, r_event_i;
  logic [7:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q, d, e, mm, ee;
  logic [3:0] avs_byteenable_i;
  logic avs_waitrequest_o, beat_accept_o, irq_o;
  logic [31:0] rd_msk[$], rd_exp[$]; // notes for pending reads
  logic beat_q[$]; // one note per expected accept: irq level seen then
  int failures = 0;
  int total_checks = 0;
  // ------------------------------------------------------------
  // device under test
  // ------------------------------------------------------------
  hbq_top #(.TICK_CYC(TC)) u_hbq_top (.clk_i(clk_i), .nrst_i(nrst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .channel_enable_i(channel_enable_i), .r_event_i(r_event_i),
    .beat_accept_o(beat_accept_o), .irq_o(irq_o));
  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // compare seen against expected, count and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one avalon access; a read leaves a note for the monitor
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] m, input logic [31:0] x);
    if (!wr) begin
      rd_msk.push_back(m);
      rd_exp.push_back(x);
    end
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    // hold the request until waitrequest is sampled low; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, 32'h0, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    bus(1'b0, a, 32'h0, m, x);
  endtask
  // read a 14-bit field and check that it lies in a band of ticks
  task automatic rng(input logic [7:0] a, input int lsb, input int lo, input int hi);
    bus(1'b0, a, 32'h0, 32'h0, 32'h0);
    check({31'h0, (q[lsb+:14] >= lo) && (q[lsb+:14] <= hi)}, 32'h1);
  endtask
  // timing config word from hold-off ticks, weight code and scale code
  function automatic logic [31:0] tcfg(input int h, input int a, input int s);
    return {8'h00, 2'b00, h[5:0], 2'b00, a[1:0], 1'b0, s[2:0], 8'h00};
  endfunction
  // candidate g ticks after the previous one; note it if it should pass
  task automatic beat(input int g, input logic acc, input logic irq);
    repeat (g * TC - 1) @(posedge clk_i);
    if (acc) beat_q.push_back(irq);
    r_event_i <= 1'b1;
    @(posedge clk_i);
    r_event_i <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // monitor: takes the oldest note whenever a result appears
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0 && rd_msk.size() > 0) begin
      mm = rd_msk.pop_front();
      ee = rd_exp.pop_front();
      if (mm !== 32'h0) check(avs_readdata_o & mm, ee);
    end
    if (beat_accept_o === 1'b1) begin
      if (beat_q.size() == 0) check(32'h1, 32'h0);
      else check({31'h0, irq_o}, {31'h0, beat_q.pop_front()});
    end
  end
  // watchdog sized well above the sequence length
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    complete_run();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hF73A));
    nrst_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 8'h00;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    channel_enable_i = 1'b0;
    r_event_i = 1'b0;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    // reset values and an unmapped place
    rd(HBQ_IDX_TIMING, 32'hFFFFFF, 32'h202400);
    rd(HBQ_IDX_CTRL, 32'hFFFFFF, 32'h0);
    rd(HBQ_IDX_STATUS, 32'hFFFFFF, 32'h0);
    rd(8'h10, 32'hFFFFFFFF, 32'h0);
    // random timing words, the unused weight code folds to weight 8
    for (int i = 0; i < 4; i++) begin
      d = $urandom();
      if (i == 0) d[13:12] = 2'b11;
      e = d & 32'h3F3700;
      if (e[13:12] == 2'b11) e[13:12] = 2'b10;
      wr(HBQ_IDX_TIMING, d);
      rd(HBQ_IDX_TIMING, 32'hFFFFFF, e);
    end
    // static hold-off of 5 ticks, scale zero
    wr(HBQ_IDX_TIMING, tcfg(5, 0, 0));
    wr(HBQ_IDX_MASK, 32'h1);
    channel_enable_i <= 1'b1;
    wr(HBQ_IDX_CTRL, 32'h1);
    beat(7, 1'b1, 1'b1);
    rng(HBQ_IDX_INTERVAL, 10, 6, 8);
    beat(3, 1'b0, 1'b1);
    rng(HBQ_IDX_INTERVAL, 10, 6, 8);
    beat(4, 1'b1, 1'b1);
    rng(HBQ_IDX_INTERVAL, 10, 6, 8);
    // interrupt clear by writing one, then masked off
    check({31'h0, irq_o}, 32'h1);
    wr(HBQ_IDX_STATUS, 32'h1);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h0);
    rd(HBQ_IDX_STATUS, 32'h1, 32'h0);
    wr(HBQ_IDX_MASK, 32'h0);
    beat(8, 1'b1, 1'b0);
    rd(HBQ_IDX_STATUS, 32'h1, 32'h1);
    // detection needs both the enable bit and the channel
    channel_enable_i <= 1'b0;
    beat(8, 1'b0, 1'b0);
    channel_enable_i <= 1'b1;
    wr(HBQ_IDX_CTRL, 32'h0);
    beat(8, 1'b0, 1'b0);
    wr(HBQ_IDX_CTRL, 32'h1);
    // settle the average near 40 ticks with weight 2
    wr(HBQ_IDX_TIMING, tcfg(5, 0, 0));
    for (int i = 0; i < 5; i++) beat(40, 1'b1, 1'b0);
    rng(HBQ_IDX_AVERAGE, 0, 37, 41);
    // scale 7/8 makes the hold-off about 34 ticks, above the static 5
    wr(HBQ_IDX_TIMING, tcfg(5, 0, 7));
    beat(20, 1'b0, 1'b0);
    beat(20, 1'b1, 1'b0);
    // weight 8 moves the average a little, weight 2 a lot
    wr(HBQ_IDX_TIMING, tcfg(5, 2, 0));
    beat(8, 1'b1, 1'b0);
    rng(HBQ_IDX_AVERAGE, 0, 33, 38);
    wr(HBQ_IDX_TIMING, tcfg(5, 0, 0));
    beat(8, 1'b1, 1'b0);
    rng(HBQ_IDX_AVERAGE, 0, 19, 24);
    // scale 4/8 of about 21 ticks holds off beyond the static 5
    wr(HBQ_IDX_TIMING, tcfg(5, 0, 4));
    beat(7, 1'b0, 1'b0);
    beat(6, 1'b1, 1'b0);
    // largest static setting
    wr(HBQ_IDX_TIMING, tcfg(63, 0, 0));
    beat(60, 1'b0, 1'b0);
    beat(6, 1'b1, 1'b0);
    repeat (5) @(posedge clk_i);
    check(beat_q.size(), 32'h0);
    check(rd_msk.size(), 32'h0);
    complete_run();
  end
endmodule // tb
